// File: shared/pcts_cfg.svh
// Timing and field constants for the pulse current trigger sequencer.
// Assumes a 20 MHz mclk; all counts derive from that rate.
`ifndef PCTS_CFG_SVH
`define PCTS_CFG_SVH
`define PCTS_CLK_HZ          20000000
`define PCTS_TICK_US         10
`define PCTS_TICK_CYC        ((`PCTS_CLK_HZ / 1000000) * `PCTS_TICK_US)
`define PCTS_ITIME_MIN_TK    4
`define PCTS_ITIME_MAX_TK    83330
`define PCTS_DIG_WIN_US      33
`define PCTS_DIG_WIN_TK      ((`PCTS_DIG_WIN_US + `PCTS_TICK_US - 1) / `PCTS_TICK_US)
`define PCTS_DIG_SPACE_US    278
`define PCTS_DIG_SPACE_TK    (`PCTS_DIG_SPACE_US / `PCTS_TICK_US)
`define PCTS_DIG_CNT_MAX     5000
`define PCTS_AVG_CNT_MAX     100
`define PCTS_DELAY_MAX_TK    10000
`define PCTS_THR_MA_MAX      5000
`define PCTS_LTHR_STEP_MA    5
`define PCTS_LINT_STEP60_TK  1667
`define PCTS_LINT_STEP50_TK  2000
`define PCTS_LINT_MIN60_TK   85000
`define PCTS_LINT_MIN50_TK   84000
`define PCTS_LINT_MAX_TK     6000000
`define PCTS_TOUT_MIN_S      1
`define PCTS_TOUT_MAX_S      63
`define PCTS_TK_PER_S        100000
`define PCTS_AUTO_MIN_TK     8
`define PCTS_AUTO_MAX_TK     83300
`define PCTS_MEV_PTT_BIT     4
`endif

// File: shared/pcts_pkg.sv
// Types shared by the pulse current trigger sequencer files.
// Constants live in pcts_cfg.svh.
package pcts_pkg;
    typedef enum logic [1:0] {PCTS_MODE_HIGH = 2'b00, PCTS_MODE_LOW = 2'b01,
                              PCTS_MODE_AVG = 2'b10} pcts_mode_e;
    typedef enum logic [1:0] {PCTS_EDGE_RISE = 2'b00, PCTS_EDGE_FALL = 2'b01,
                              PCTS_EDGE_FREE = 2'b10} pcts_edge_e;
    typedef enum logic [3:0] {
        PCTS_ST_IDLE   = 4'b0000,
        PCTS_ST_ARM    = 4'b0001,
        PCTS_ST_DELAY  = 4'b0010,
        PCTS_ST_CONV   = 4'b0011,
        PCTS_ST_GAP    = 4'b0100,
        PCTS_ST_AUTO1  = 4'b0101,
        PCTS_ST_AUTO2  = 4'b0110,
        PCTS_ST_AUTO3  = 4'b0111,
        PCTS_ST_LWAIT  = 4'b1000,
        PCTS_ST_LINT   = 4'b1001,
        PCTS_ST_STOP   = 4'b1010
    } pcts_state_e;
endpackage

// File: rtl/pcts_tick.sv
// 10 us timebase strobe divided down from mclk.
// Assumes mclk runs at the rate given in pcts_cfg.svh.
`timescale 1ns/100ps
`default_nettype none
`include "pcts_cfg.svh"
module pcts_tick
#(
    parameter int DIV = `PCTS_TICK_CYC
)
(
    input  wire logic mclk,
    input  wire logic nrst,
    output logic      tick
);
    logic [15:0] cnt_q;
    wire         wrap = (cnt_q == 16'(DIV - 1));

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            cnt_q <= 16'h0000;
        else
            cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            tick <= 1'b0;
        else
            tick <= wrap;
endmodule
`default_nettype wire

// File: rtl/pcts_seq.sv
// Pulse current trigger sequencer: detection, delay, windows, digitize, long integration.
// Assumes cur_ma comes from the converter front end on mclk; commands are one-cycle pulses on mclk.
`timescale 1ns/100ps
`default_nettype none
`include "pcts_cfg.svh"

// Operation
// - Each of high, low, average windows is settable from 40us to 0.8333s.
// - Auto setup times pulse high and low, derives three windows, 40us to 0.8333s.
// - Derived windows stay until another auto setup or manual write.
// - Synced conversion starts only after threshold crossing plus full trigger delay.
// - Sync off runs digitize bursts with a fixed 40us window.
// - Digitize aligns to rising edge (high, average) or falling edge (low), then delays.
// - Digitize burst length is the programmed count, 1 to 5000.
// - Digitize readings are spaced 270us apart.
// - Digitize raises no-pulse when no pulse is detected.
// - Detect threshold 0 to 5A in 1mA; pulses below it are ignored.
// - Threshold detection gates measurement with sync on or off.
// - Trigger delay 0 to 0.1s in 10us steps, rounded up.
// - Long integration up to 60s, minimum 0.85s at 60Hz, 0.84s at 50Hz.
// - Long time rounds down to 16.667ms or 20ms steps; readback shows rounded value.
// - Long auto setup times rising-to-rising period and keeps it.
// - Long start threshold 0 to 5A in 5mA steps.
// - Long start edge is rising, falling or free-run.
// - Free-run starts at once with no pulse search.
// - Rising or falling start flags no-pulse after a 1 to 63s timeout.
// - Search on keeps searching after timeout; off abandons at first timeout.
// - Synced averaging count is 1 to 100 pulses.
// - Pulse trigger timeout event flag sits at bit 4 of measurement events.
module pcts_seq
    import pcts_pkg::*;
#(
    parameter int TK_PER_S = `PCTS_TK_PER_S
)
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [12:0] cur_ma,
    input  wire logic        pulse_current_function,
    input  wire logic        long_integration_function,
    input  wire logic [1:0]  pc_mode,
    input  wire logic        trigger_sync_enable,
    input  wire logic [12:0] detect_threshold,
    input  wire logic [16:0] trig_delay_us,
    input  wire logic [12:0] read_count,
    input  wire logic        itime_wr,
    input  wire logic [1:0]  itime_sel,
    input  wire logic [16:0] itime_tk,
    input  wire logic        itime_auto,
    input  wire logic        line_50hz,
    input  wire logic        lint_wr,
    input  wire logic [22:0] lint_tk,
    input  wire logic        lint_auto,
    input  wire logic [12:0] lint_threshold,
    input  wire logic [1:0]  start_edge_select,
    input  wire logic [5:0]  timeout_s,
    input  wire logic        search_enable,
    input  wire logic        read_trig,
    input  wire logic        mev_clear,
    output logic             conv_start,
    output logic [16:0]      conv_window_tk,
    output logic             busy,
    output logic [16:0]      itime_high,
    output logic [16:0]      itime_low,
    output logic [16:0]      itime_avg,
    output logic [22:0]      lint_time,
    output logic             no_pulse,
    output logic [15:0]      meas_event
);
    logic tick;
    pcts_tick u_tick
    (
        .mclk (mclk),
        .nrst (nrst),
        .tick (tick)
    );

    function automatic logic [16:0] clamp_itime(input logic [16:0] v);
        if (v < 17'(`PCTS_ITIME_MIN_TK))
            return 17'(`PCTS_ITIME_MIN_TK);
        else if (v > 17'(`PCTS_ITIME_MAX_TK))
            return 17'(`PCTS_ITIME_MAX_TK);
        return v;
    endfunction

    function automatic logic [12:0] sat13(input logic [12:0] v, input logic [12:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    pcts_state_e  st_q, st_d;
    logic [22:0]  tcnt_q;
    logic [22:0]  tout_q;
    logic [12:0]  rcnt_q;
    logic [16:0]  hi_q;
    logic         lint_auto_q;
    logic         auto_pc_q;
    logic         cur_hi_q;
    logic         search_q;
    logic         ptt_q;
    logic [16:0]  ih_q, il_q, ia_q;
    logic [22:0]  lt_q;

    // Threshold compare, saturated to the 5A full scale
    wire [12:0] thr_pc   = sat13(detect_threshold, 13'(`PCTS_THR_MA_MAX));
    wire [12:0] thr_li   = sat13(lint_threshold - (lint_threshold % 13'(`PCTS_LTHR_STEP_MA)),
                                 13'(`PCTS_THR_MA_MAX));
    wire        in_lint  = long_integration_function;
    wire [12:0] thr_act  = in_lint ? thr_li : thr_pc;
    wire        cur_hi   = (cur_ma >= thr_act) && (thr_act != 13'h0000 || cur_ma != 13'h0000);
    wire        rise     = cur_hi && !cur_hi_q;
    wire        fall     = !cur_hi && cur_hi_q;

    wire        want_fall = in_lint ? (start_edge_select == PCTS_EDGE_FALL)
                                    : (pc_mode == PCTS_MODE_LOW);
    wire        start_edge = want_fall ? fall : rise;
    wire        free_run   = in_lint && (start_edge_select == PCTS_EDGE_FREE);

    // Delay rounded up to whole 10us ticks
    wire [16:0] dly_cap  = (trig_delay_us > 17'(`PCTS_DELAY_MAX_TK * `PCTS_TICK_US))
                           ? 17'(`PCTS_DELAY_MAX_TK * `PCTS_TICK_US) : trig_delay_us;
    wire [22:0] dly_tk   = 23'((dly_cap + 17'(`PCTS_TICK_US - 1)) / 17'(`PCTS_TICK_US));

    wire [12:0] cnt_lim  = trigger_sync_enable ? 13'(`PCTS_AVG_CNT_MAX) : 13'(`PCTS_DIG_CNT_MAX);
    wire [12:0] cnt_sat  = sat13(read_count, cnt_lim);
    wire [12:0] cnt_eff  = (cnt_sat == 13'h0000) ? 13'h0001 : cnt_sat;

    wire [16:0] mode_win = (pc_mode == PCTS_MODE_HIGH) ? ih_q :
                           (pc_mode == PCTS_MODE_LOW)  ? il_q : ia_q;
    wire [16:0] win_tk   = trigger_sync_enable ? mode_win : 17'(`PCTS_DIG_WIN_TK);
    wire [22:0] gap_tk   = trigger_sync_enable ? 23'h000001
                           : 23'(`PCTS_DIG_SPACE_TK - `PCTS_DIG_WIN_TK);
    wire [22:0] tout_tk  = 23'(((timeout_s < 6'(`PCTS_TOUT_MIN_S)) ? 6'(`PCTS_TOUT_MIN_S) : timeout_s))
                           * 23'(TK_PER_S);

    wire [22:0] step_tk  = line_50hz ? 23'(`PCTS_LINT_STEP50_TK) : 23'(`PCTS_LINT_STEP60_TK);
    wire [22:0] lmin_tk  = line_50hz ? 23'(`PCTS_LINT_MIN50_TK) : 23'(`PCTS_LINT_MIN60_TK);
    wire [22:0] lcap     = (lint_tk > 23'(`PCTS_LINT_MAX_TK)) ? 23'(`PCTS_LINT_MAX_TK) : lint_tk;
    wire [22:0] lstep    = lcap - (lcap % step_tk);
    wire [22:0] lset     = (lstep < lmin_tk) ? lmin_tk : lstep;
    wire [22:0] lauto    = (tcnt_q < lmin_tk) ? lmin_tk
                           : ((tcnt_q > 23'(`PCTS_LINT_MAX_TK)) ? 23'(`PCTS_LINT_MAX_TK)
                           : tcnt_q - (tcnt_q % step_tk));

    wire        t_done   = tick && (tcnt_q <= 23'h000001);
    wire        t_out    = tick && (tout_q == 23'h000001);
    wire        go       = read_trig && (pulse_current_function || in_lint);
    wire        ptt_set  = t_out && (st_q == PCTS_ST_ARM || st_q == PCTS_ST_LWAIT
                           || st_q == PCTS_ST_AUTO1);

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            PCTS_ST_IDLE:
                if (itime_auto && pulse_current_function)
                    st_d = PCTS_ST_AUTO1;
                else if (lint_auto && in_lint)
                    st_d = PCTS_ST_AUTO1;
                else if (go && free_run)
                    st_d = PCTS_ST_LINT;
                else if (go)
                    st_d = in_lint ? PCTS_ST_LWAIT : PCTS_ST_ARM;
            PCTS_ST_ARM:
                if (start_edge)
                    st_d = PCTS_ST_DELAY;
                else if (t_out)
                    st_d = PCTS_ST_STOP;
            PCTS_ST_DELAY:
                if (t_done)
                    st_d = PCTS_ST_CONV;
            PCTS_ST_CONV:
                if (t_done)
                    st_d = (rcnt_q <= 13'h0001) ? PCTS_ST_IDLE : PCTS_ST_GAP;
            PCTS_ST_GAP:
                if (t_done)
                    st_d = trigger_sync_enable ? PCTS_ST_ARM : PCTS_ST_CONV;
            PCTS_ST_AUTO1:
                if (rise)
                    st_d = PCTS_ST_AUTO2;
                else if (t_out)
                    st_d = PCTS_ST_STOP;
            PCTS_ST_AUTO2:
                if (fall && !lint_auto_q)
                    st_d = PCTS_ST_AUTO3;
                else if (rise && lint_auto_q)
                    st_d = PCTS_ST_IDLE;
            PCTS_ST_AUTO3:
                if (rise)
                    st_d = PCTS_ST_IDLE;
            PCTS_ST_LWAIT:
                if (start_edge)
                    st_d = PCTS_ST_LINT;
                else if (t_out && !search_q)
                    st_d = PCTS_ST_STOP;
            PCTS_ST_LINT:
                if (t_done)
                    st_d = PCTS_ST_IDLE;
            PCTS_ST_STOP:
                if (go)
                    st_d = in_lint ? PCTS_ST_LWAIT : PCTS_ST_ARM;
                else if (search_enable && !search_q && in_lint)
                    st_d = PCTS_ST_LWAIT;
                else if (!go)
                    st_d = PCTS_ST_IDLE;
            default:
                st_d = PCTS_ST_IDLE;
        endcase
    end

    wire enter = (st_d != st_q);

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
            st_q     <= PCTS_ST_IDLE;
            cur_hi_q <= 1'b0;
            search_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            cur_hi_q <= cur_hi;
            search_q <= search_enable;
        end

    // Phase timer, reloaded on state entry, counted on the 10us strobe
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            tcnt_q <= 23'h000000;
        else if (enter && st_d == PCTS_ST_DELAY)
            tcnt_q <= dly_tk + 23'h000001;
        else if (enter && st_d == PCTS_ST_CONV)
            tcnt_q <= 23'(win_tk);
        else if (enter && st_d == PCTS_ST_GAP)
            tcnt_q <= gap_tk;
        else if (enter && st_d == PCTS_ST_LINT)
            tcnt_q <= lt_q;
        else if (enter && st_d == PCTS_ST_AUTO2)
            tcnt_q <= 23'h000000;
        else if (st_q == PCTS_ST_AUTO2 || st_q == PCTS_ST_AUTO3)
            tcnt_q <= tick ? tcnt_q + 23'h000001 : tcnt_q;
        else if (tick && tcnt_q != 23'h000000)
            tcnt_q <= tcnt_q - 23'h000001;

    // Search timeout rearms while waiting, so a kept search retries
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            tout_q <= 23'h000000;
        else if (enter || t_out)
            tout_q <= tout_tk;
        else if (tick && tout_q != 23'h000000)
            tout_q <= tout_q - 23'h000001;

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
            rcnt_q      <= 13'h0000;
            lint_auto_q <= 1'b0;
            auto_pc_q   <= 1'b0;
            hi_q        <= 17'h00000;
        end
        else
        begin
            if (st_q == PCTS_ST_IDLE && (go || enter))
                rcnt_q <= cnt_eff;
            else if (st_q == PCTS_ST_CONV && t_done)
                rcnt_q <= rcnt_q - 13'h0001;
            if (st_q == PCTS_ST_IDLE && enter)
            begin
                lint_auto_q <= lint_auto && in_lint;
                auto_pc_q   <= itime_auto && pulse_current_function;
            end
            if (st_q == PCTS_ST_AUTO2 && st_d == PCTS_ST_AUTO3)
                hi_q <= tcnt_q[16:0];
        end

    wire auto_pc_done = (st_q == PCTS_ST_AUTO3) && rise && auto_pc_q;
    wire [16:0] lo_tk = tcnt_q[16:0] - hi_q;

    // Windows: manual write or auto result, kept otherwise
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
            ih_q <= 17'(`PCTS_ITIME_MIN_TK);
            il_q <= 17'(`PCTS_ITIME_MIN_TK);
            ia_q <= 17'(`PCTS_ITIME_MIN_TK);
            lt_q <= 23'(`PCTS_LINT_MIN60_TK);
        end
        else
        begin
            if (auto_pc_done)
            begin
                ih_q <= clamp_itime(hi_q >> 1);
                il_q <= clamp_itime(lo_tk >> 1);
                ia_q <= clamp_itime(tcnt_q[16:0]);
            end
            else if (itime_wr)
            begin
                if (itime_sel == PCTS_MODE_HIGH)
                    ih_q <= clamp_itime(itime_tk);
                if (itime_sel == PCTS_MODE_LOW)
                    il_q <= clamp_itime(itime_tk);
                if (itime_sel == PCTS_MODE_AVG)
                    ia_q <= clamp_itime(itime_tk);
            end
            if (st_q == PCTS_ST_AUTO2 && rise && lint_auto_q)
                lt_q <= lauto;
            else if (lint_wr)
                lt_q <= lset;
        end

    // Timeout flag: a new timeout wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            ptt_q <= 1'b0;
        else if (ptt_set)
            ptt_q <= 1'b1;
        else if (mev_clear || (st_q != st_d && st_d == PCTS_ST_CONV))
            ptt_q <= 1'b0;

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
            conv_start     <= 1'b0;
            conv_window_tk <= 17'h00000;
            busy           <= 1'b0;
            itime_high     <= 17'h00000;
            itime_low      <= 17'h00000;
            itime_avg      <= 17'h00000;
            lint_time      <= 23'h000000;
            no_pulse       <= 1'b0;
            meas_event     <= 16'h0000;
        end
        else
        begin
            conv_start     <= enter && (st_d == PCTS_ST_CONV || st_d == PCTS_ST_LINT);
            conv_window_tk <= win_tk;
            busy           <= (st_q != PCTS_ST_IDLE) && (st_q != PCTS_ST_STOP);
            itime_high     <= ih_q;
            itime_low      <= il_q;
            itime_avg      <= ia_q;
            lint_time      <= lt_q;
            no_pulse       <= ptt_q;
            meas_event     <= 16'(ptt_q) << `PCTS_MEV_PTT_BIT;
        end

    // Checks
    int unsigned gap_cnt_q;
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            gap_cnt_q <= 0;
        else if (st_q == PCTS_ST_DELAY)
            gap_cnt_q <= tick ? gap_cnt_q + 1 : gap_cnt_q;
        else
            gap_cnt_q <= 0;

    property p_delay_full;
        @(posedge mclk) disable iff (!nrst)
        (st_q == PCTS_ST_DELAY && st_d == PCTS_ST_CONV) |-> (gap_cnt_q >= 32'(dly_tk));
    endproperty
    a_delay_full: assert property (p_delay_full) else $error("conversion before delay elapsed");

    property p_arm_edge;
        @(posedge mclk) disable iff (!nrst)
        (st_q == PCTS_ST_ARM && st_d == PCTS_ST_DELAY) |-> start_edge;
    endproperty
    a_arm_edge: assert property (p_arm_edge) else $error("delay entered without detect edge");

    property p_dig_win;
        @(posedge mclk) disable iff (!nrst)
        (enter && st_d == PCTS_ST_CONV && !trigger_sync_enable) |=> (tcnt_q == 23'(`PCTS_DIG_WIN_TK));
    endproperty
    a_dig_win: assert property (p_dig_win) else $error("digitize window wrong");

    property p_dig_gap;
        @(posedge mclk) disable iff (!nrst)
        (enter && st_d == PCTS_ST_GAP && !trigger_sync_enable)
            |=> (tcnt_q == 23'(`PCTS_DIG_SPACE_TK - `PCTS_DIG_WIN_TK));
    endproperty
    a_dig_gap: assert property (p_dig_gap) else $error("digitize spacing wrong");

    property p_ptt_out;
        @(posedge mclk) disable iff (!nrst)
        ptt_set |=> ##1 (no_pulse && meas_event[`PCTS_MEV_PTT_BIT]);
    endproperty
    a_ptt_out: assert property (p_ptt_out) else $error("timeout flag not shown");

    property p_free_run;
        @(posedge mclk) disable iff (!nrst)
        (st_q == PCTS_ST_IDLE && go && free_run && !lint_auto) |=> (st_q == PCTS_ST_LINT);
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run did not start at once");

    property p_search_kept;
        @(posedge mclk) disable iff (!nrst)
        (st_q == PCTS_ST_LWAIT && t_out && search_q && !start_edge) |=> (st_q == PCTS_ST_LWAIT);
    endproperty
    a_search_kept: assert property (p_search_kept) else $error("search dropped while enabled");

    property p_lint_step;
        @(posedge mclk) disable iff (!nrst)
        lint_wr && !(st_q == PCTS_ST_AUTO2 && rise && lint_auto_q)
            |=> (lt_q % step_tk == 0 || lt_q == lmin_tk) && lt_q >= lmin_tk;
    endproperty
    a_lint_step: assert property (p_lint_step) else $error("long time not on a step");

    property p_itime_range;
        @(posedge mclk) disable iff (!nrst)
        ih_q >= 17'(`PCTS_ITIME_MIN_TK) && ih_q <= 17'(`PCTS_ITIME_MAX_TK);
    endproperty
    a_itime_range: assert property (p_itime_range) else $error("high window out of range");

    c_dig_burst: cover property (@(posedge mclk) disable iff (!nrst)
        st_q == PCTS_ST_GAP && !trigger_sync_enable ##1 st_q == PCTS_ST_CONV);
    c_sync_conv: cover property (@(posedge mclk) disable iff (!nrst)
        st_q == PCTS_ST_DELAY ##1 st_q == PCTS_ST_CONV);
    c_timeout: cover property (@(posedge mclk) disable iff (!nrst) ptt_set);
    c_auto: cover property (@(posedge mclk) disable iff (!nrst) auto_pc_done);
endmodule
`default_nettype wire

// File: testbench/pcts_load.sv
// Partner model: pulsed load current seen by the sense front end.
// Assumes run is raised to start a train; each period opens with its low half.
`timescale 1ns/100ps
`default_nettype none
module pcts_load
#(
    parameter int HALF = 4000
)
(
    input  wire logic        mclk,
    input  wire logic        run,
    input  wire logic [12:0] amp,
    output logic [12:0]      cur_ma = 13'h0000
);
    int cnt = 0;
    always @(posedge mclk)
    begin
        cnt <= run ? (cnt + 1) % (2 * HALF) : 0;
        cur_ma <= (run && cnt >= HALF) ? amp : 13'h0000;
    end
endmodule
`default_nettype wire

// File: testbench/pulse_current_trigger_sequencer_test.sv
// Bench for pcts_seq: settings, synced reading, digitize, timeout, auto setup, free run.
// Assumes the 10 us tick is 200 mclk cycles.
`timescale 1ns/100ps
`default_nettype none
module pulse_current_trigger_sequencer_test;
    localparam int HALF = 4000;
    logic        mclk = 1'b0, nrst = 1'b0, run = 1'b0, sync = 1'b1, trig = 1'b0;
    logic        wr = 1'b0, lwr = 1'b0, l50 = 1'b1, cs, busy, np;
    logic        auto = 1'b0, mclr = 1'b0, lint = 1'b0;
    logic [5:0]  tos = 6'h01;
    logic [1:0]  mode = 2'h0, sel = 2'h0;
    logic [12:0] amp = 13'h07d0, thr = 13'h03e8, rc = 13'h0001, cur;
    logic [16:0] dly = 17'h00019, itk = 17'h00064, win, ih, il, ia;
    logic [22:0] ltk = 23'h0186a1, lt;
    logic [15:0] mev;
    int          error_cnt = 0, compares = 0, cyc = 0, n, t0, gap;
    always #25 mclk = ~mclk;
    pcts_load #(.HALF(HALF)) load (.mclk(mclk), .run(run), .amp(amp), .cur_ma(cur));
    // Timeout scaled to 50 ticks per second so a search timeout fits in the run
    pcts_seq #(.TK_PER_S(50)) uut (.mclk(mclk), .nrst(nrst), .cur_ma(cur), .pulse_current_function(1'b1),
        .long_integration_function(lint), .pc_mode(mode), .trigger_sync_enable(sync),
        .detect_threshold(thr), .trig_delay_us(dly), .read_count(rc), .itime_wr(wr),
        .itime_sel(sel), .itime_tk(itk), .itime_auto(auto), .line_50hz(l50), .lint_wr(lwr),
        .lint_tk(ltk), .lint_auto(1'b0), .lint_threshold(thr), .start_edge_select(2'h2),
        .timeout_s(tos), .search_enable(1'b1), .read_trig(trig), .mev_clear(mclr),
        .conv_start(cs), .conv_window_tk(win), .busy(busy), .itime_high(ih), .itime_low(il),
        .itime_avg(ia), .lint_time(lt), .no_pulse(np), .meas_event(mev));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Starts a pulse train with a trigger or auto setup request and counts conversion starts
    task automatic go(input logic [1:0] m, input logic s, input logic a);
        int t1;
        mode = m;
        sync = s;
        run = 1'b1;
        trig = !a;
        auto = a;
        @(negedge mclk);
        trig = 1'b0;
        auto = 1'b0;
        n = 0;
        t1 = 0;
        for (int i = 1; i < 12000; i++)
        begin
            @(negedge mclk);
            if (cs === 1'b1)
            begin
                n++;
                if (n == 1)
                    t0 = i;
                else
                    t1 = i;
            end
        end
        gap = t1 - t0;
        // Train stays on until idle, so an auto setup sees its second rise
        for (int i = 0; i < 20000 && busy !== 1'b0; i++)
            @(negedge mclk);
        run = 1'b0;
        // Load must see run low, so the next train opens with its low half
        repeat (2) @(negedge mclk);
    endtask
    // Free-run long start, then a reset in mid-integration
    task automatic free_run_abort();
        lint = 1'b1;
        trig = 1'b1;
        @(negedge mclk);
        trig = 1'b0;
        chk(cs, 1);
        @(negedge mclk);
        chk(busy, 1);
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        lint = 1'b0;
        repeat (2) @(negedge mclk);
        chk(busy, 0);
        chk(lt, 85000);
        chk(ih, 4);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (2) @(negedge mclk);
        chk(ih, 4);
        chk(lt, 85000);
        sel = 2'h1;
        wr = 1'b1;
        lwr = 1'b1;
        @(negedge mclk);
        itk = 17'h00002;
        sel = 2'h0;
        lwr = 1'b0;
        @(negedge mclk);
        wr = 1'b0;
        @(negedge mclk);
        chk(il, 100);
        chk(ih, 4);
        chk(lt, 100000);
        go(2'h0, 1'b1, 1'b0);
        chk(n, 1);
        chk(t0 >= HALF + 600 && t0 <= HALF + 1400, 1);
        dly = 17'h00000;
        rc = 13'h0002;
        go(2'h2, 1'b0, 1'b0);
        chk(n, 2);
        chk(gap, 5400);
        chk(win, 4);
        chk(t0 >= HALF && t0 <= HALF + 800, 1);
        rc = 13'h0001;
        go(2'h1, 1'b0, 1'b0);
        chk(n, 1);
        chk(t0 >= 2 * HALF && t0 <= 2 * HALF + 800, 1);
        amp = 13'h01f4;
        tos = 6'h00;
        go(2'h0, 1'b1, 1'b0);
        chk(n, 0);
        chk(np, 1);
        chk(mev, 16'h0010);
        mclr = 1'b1;
        @(negedge mclk);
        mclr = 1'b0;
        @(negedge mclk);
        chk(np, 0);
        chk(mev, 16'h0000);
        amp = 13'h07d0;
        go(2'h0, 1'b1, 1'b1);
        chk(ih >= 9 && ih <= 10, 1);
        chk(il, 10);
        chk(ia >= 39 && ia <= 40, 1);
        free_run_abort();
        conclude();
    end
endmodule
`default_nettype wire
